// *** hw/hmc_pkg.sv ***
// Constants and types shared by the holdover mode control block.
package hmc_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    // Printed offsets are not all multiples of four, so each one is an index.
    localparam logic [9:0] HMC_IDX_FREQ_LO  = 10'h03e;
    localparam logic [9:0] HMC_IDX_FREQ_MID = 10'h03f;
    localparam logic [9:0] HMC_IDX_CTRL     = 10'h040;
    localparam int unsigned HMC_ADDR_W      = 12;
    localparam logic [HMC_ADDR_W-1:0] HMC_ADDR_FREQ_LO  = {HMC_IDX_FREQ_LO, 2'b00};
    localparam logic [HMC_ADDR_W-1:0] HMC_ADDR_FREQ_MID = {HMC_IDX_FREQ_MID, 2'b00};
    localparam logic [HMC_ADDR_W-1:0] HMC_ADDR_CTRL     = {HMC_IDX_CTRL, 2'b00};

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned HMC_BIT_AUTO_AVG  = 7;
    localparam int unsigned HMC_BIT_FAST_AVG  = 6;
    localparam int unsigned HMC_BIT_READ_AVG  = 5;
    localparam int unsigned HMC_MINI_MSB      = 4;
    localparam int unsigned HMC_MINI_LSB      = 3;
    localparam int unsigned HMC_FTOP_MSB      = 2;
    localparam int unsigned HMC_FREQ_W        = 19;
    localparam int unsigned HMC_FMID_LSB      = 8;
    localparam int unsigned HMC_FTOP_LSB      = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HMC_RST_CTRL     = 8'h88;
    localparam logic [7:0] HMC_RST_FREQ_LO  = 8'h00;
    localparam logic [7:0] HMC_RST_FREQ_MID = 8'h00;

    // ------------------------------------------------------------
    // Short-loss hold behaviour
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMC_MINI_AS_FULL = 2'h0,
        HMC_MINI_FREEZE  = 2'h1,
        HMC_MINI_FAST    = 2'h2,
        HMC_MINI_SLOW    = 2'h3
    } hmc_mini_t;

    // Where the loop frequency currently comes from.
    typedef enum logic [1:0] {
        HMC_SRC_TRACK,
        HMC_SRC_MINI,
        HMC_SRC_FULL
    } hmc_src_t;

endpackage : hmc_pkg

// *** hw/hmc_holdover_mode_control.sv ***
// Holdover mode control register bank with APB access and frequency selection.
//
// Behaviour
// - With read-average clear, frequency word reads return the last written value.
// - With read-average set, reads return fast or slow averaged frequency per rate bit.
// - Short-loss field 00: frequency derived exactly as in full holdover.
// - Short-loss field 01: output frequency frozen at the moment of input loss.
// - Short-loss field 10: frequency taken from the fast averager.
// - Control bits 2:0 hold word bits 18:16; middle byte is a separate register.
`timescale 1ns/1ps
`default_nettype none

module hmc_holdover_mode_control
    import hmc_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    pclk_en,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [HMC_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output var  logic [31:0]             prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    // Loop status and frequencies from the primary timing loop
    input  wire logic                    loop_locked,
    input  wire logic                    loop_full_holdover,
    input  wire logic                    input_short_loss,
    input  wire logic [HMC_FREQ_W-1:0]   live_freq,
    input  wire logic [HMC_FREQ_W-1:0]   fast_avg_freq,
    input  wire logic [HMC_FREQ_W-1:0]   slow_avg_freq,
    // Frequency and holdover state flags handed back to the primary timing loop
    output var  logic [HMC_FREQ_W-1:0]   hold_freq,
    output var  logic                    mini_hold_active,
    output var  logic                    full_hold_active
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [HMC_FREQ_W-1:0] avg_pick(
        input logic                  fast,
        input logic [HMC_FREQ_W-1:0] f_avg,
        input logic [HMC_FREQ_W-1:0] s_avg
    );
        avg_pick = fast ? f_avg : s_avg;
    endfunction

    function automatic logic [7:0] lane_merge(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic       en
    );
        lane_merge = en ? new_v : old_v;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]            ctrl_q;
    logic [7:0]            ctrl_d;
    logic [7:0]            freq_lo_q;
    logic [7:0]            freq_lo_d;
    logic [7:0]            freq_mid_q;
    logic [7:0]            freq_mid_d;
    logic [31:0]           prdata_q;
    logic [31:0]           prdata_d;
    logic                  pready_q;
    logic                  pready_d;
    logic                  pslverr_q;
    logic                  pslverr_d;

    logic                  setup_phase;
    logic                  wr_commit;
    logic                  hit_lo;
    logic                  hit_mid;
    logic                  hit_ctrl;
    logic                  hit_any;
    logic [HMC_FREQ_W-1:0] written_freq;
    logic [HMC_FREQ_W-1:0] avg_freq;
    logic [HMC_FREQ_W-1:0] read_freq;
    hmc_mini_t             mini_mode;

    assign mini_mode    = hmc_mini_t'(ctrl_q[HMC_MINI_MSB:HMC_MINI_LSB]);
    assign written_freq = {ctrl_q[HMC_FTOP_MSB:0], freq_mid_q, freq_lo_q};
    assign avg_freq     = avg_pick(ctrl_q[HMC_BIT_FAST_AVG], fast_avg_freq, slow_avg_freq);

    // The averaged word is sampled as a whole per read, so software reading
    // the three bytes separately may see them from different moments.
    assign read_freq = ctrl_q[HMC_BIT_READ_AVG] ? avg_freq
                                                : written_freq;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Data are prepared in the setup cycle so pready can rise in the first
    // access cycle straight from a flip-flop.
    assign setup_phase = psel && !penable;
    assign wr_commit   = psel && penable && pready_q && pwrite && !pslverr_q;
    assign hit_lo      = (paddr == HMC_ADDR_FREQ_LO);
    assign hit_mid     = (paddr == HMC_ADDR_FREQ_MID);
    assign hit_ctrl    = (paddr == HMC_ADDR_CTRL);
    assign hit_any     = hit_lo || hit_mid || hit_ctrl;

    always_comb
    begin
        ctrl_d     = ctrl_q;
        freq_lo_d  = freq_lo_q;
        freq_mid_d = freq_mid_q;
        prdata_d   = prdata_q;
        pready_d   = setup_phase;
        pslverr_d  = setup_phase && !hit_any;
        if (setup_phase && !pwrite)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_lo)
            begin
                prdata_d[7:0] = read_freq[HMC_FMID_LSB-1:0];
            end
            else if (hit_mid)
            begin
                prdata_d[7:0] = read_freq[HMC_FTOP_LSB-1:HMC_FMID_LSB];
            end
            else if (hit_ctrl)
            begin
                prdata_d[7:0] = {ctrl_q[7:HMC_MINI_LSB],
                                 read_freq[HMC_FREQ_W-1:HMC_FTOP_LSB]};
            end
        end
        if (wr_commit)
        begin
            if (hit_lo)
            begin
                freq_lo_d = lane_merge(freq_lo_q, pwdata[7:0], pstrb[0]);
            end
            if (hit_mid)
            begin
                freq_mid_d = lane_merge(freq_mid_q, pwdata[7:0], pstrb[0]);
            end
            if (hit_ctrl)
            begin
                ctrl_d = lane_merge(ctrl_q, pwdata[7:0], pstrb[0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q     <= HMC_RST_CTRL;
            freq_lo_q  <= HMC_RST_FREQ_LO;
            freq_mid_q <= HMC_RST_FREQ_MID;
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
        end
        else if (pclk_en)
        begin
            ctrl_q     <= ctrl_d;
            freq_lo_q  <= freq_lo_d;
            freq_mid_q <= freq_mid_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Holdover frequency selection
    // ------------------------------------------------------------
    logic [HMC_FREQ_W-1:0] frozen_q;
    logic [HMC_FREQ_W-1:0] frozen_d;
    logic                  loss_q;
    logic                  loss_d;
    hmc_src_t              src_q;
    hmc_src_t              src_d;
    logic [HMC_FREQ_W-1:0] hold_freq_q;
    logic [HMC_FREQ_W-1:0] hold_freq_d;
    logic [HMC_FREQ_W-1:0] full_freq;
    logic [HMC_FREQ_W-1:0] mini_freq;
    logic                  loss_start;
    logic                  mini_act_q;
    logic                  mini_act_d;
    logic                  full_act_q;
    logic                  full_act_d;

    // Full holdover uses the averager when enabled, else the written word;
    // the same value is what short-loss field 00 holds; freeze keeps live_freq.
    assign full_freq  = ctrl_q[HMC_BIT_AUTO_AVG] ? avg_freq : written_freq;
    assign loss_start = input_short_loss && !loss_q && loop_locked;

    always_comb
    begin
        unique case (mini_mode)
            HMC_MINI_AS_FULL: mini_freq = full_freq;
            HMC_MINI_FREEZE:  mini_freq = frozen_q;
            HMC_MINI_FAST:    mini_freq = fast_avg_freq;
            HMC_MINI_SLOW:    mini_freq = slow_avg_freq;
        endcase
    end

    always_comb
    begin
        loss_d      = input_short_loss;
        frozen_d    = frozen_q;
        src_d       = src_q;
        hold_freq_d = hold_freq_q;
        // The freeze value is the live frequency at the very cycle of loss,
        // so it carries none of the disturbance that follows.
        if (loss_start)
        begin
            frozen_d = live_freq;
        end
        unique case (src_q)
            HMC_SRC_TRACK:
            begin
                if (loop_full_holdover)
                begin
                    src_d = HMC_SRC_FULL;
                end
                else if (loss_start)
                begin
                    src_d = HMC_SRC_MINI;
                end
            end
            HMC_SRC_MINI:
            begin
                if (loop_full_holdover)
                begin
                    src_d = HMC_SRC_FULL;
                end
                else if (!input_short_loss)
                begin
                    src_d = HMC_SRC_TRACK;
                end
            end
            HMC_SRC_FULL:
            begin
                if (!loop_full_holdover)
                begin
                    src_d = HMC_SRC_TRACK;
                end
            end
            default:
            begin
                src_d = HMC_SRC_TRACK;
            end
        endcase
        unique case (src_d)
            HMC_SRC_MINI: hold_freq_d = (loss_start && mini_mode == HMC_MINI_FREEZE)
                                        ? live_freq : mini_freq;
            HMC_SRC_FULL: hold_freq_d = full_freq;
            default:      hold_freq_d = live_freq;
        endcase
        // The state flags get their own flops so the ports carry no decode logic.
        mini_act_d = (src_d == HMC_SRC_MINI);
        full_act_d = (src_d == HMC_SRC_FULL);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frozen_q    <= '0;
            loss_q      <= 1'b0;
            src_q       <= HMC_SRC_TRACK;
            hold_freq_q <= '0;
            mini_act_q  <= 1'b0;
            full_act_q  <= 1'b0;
        end
        else if (pclk_en)
        begin
            frozen_q    <= frozen_d;
            loss_q      <= loss_d;
            src_q       <= src_d;
            hold_freq_q <= hold_freq_d;
            mini_act_q  <= mini_act_d;
            full_act_q  <= full_act_d;
        end
    end

    assign hold_freq        = hold_freq_q;
    assign mini_hold_active = mini_act_q;
    assign full_hold_active = full_act_q;

endmodule // hmc_holdover_mode_control

`default_nettype wire

// *** bench/hmc_monitor.sv ***
// Concurrent checks on the ports of the holdover mode control block.
`timescale 1ns/1ps
`default_nettype none

module hmc_monitor
    import hmc_pkg::*;
(
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  pclk_en,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [HMC_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Loop side
    input wire logic                  loop_locked,
    input wire logic                  loop_full_holdover,
    input wire logic                  input_short_loss,
    input wire logic [HMC_FREQ_W-1:0] live_freq,
    input wire logic [HMC_FREQ_W-1:0] fast_avg_freq,
    input wire logic [HMC_FREQ_W-1:0] slow_avg_freq,
    input wire logic [HMC_FREQ_W-1:0] hold_freq,
    input wire logic                  mini_hold_active
);
    // ------------------------------------------------
    // Shadow registers
    // ------------------------------------------------
    logic [7:0]            ctrl_q, ctrl_d, lo_q, lo_d, mid_q, mid_d;
    logic [HMC_FREQ_W-1:0] avg, full_src, mini_avg;
    logic                  wr_ok, mapped;

    always_comb
    begin
        wr_ok    = psel && penable && pready && pwrite && pstrb[0];
        ctrl_d   = (wr_ok && paddr == HMC_ADDR_CTRL) ? pwdata[7:0] : ctrl_q;
        lo_d     = (wr_ok && paddr == HMC_ADDR_FREQ_LO) ? pwdata[7:0] : lo_q;
        mid_d    = (wr_ok && paddr == HMC_ADDR_FREQ_MID) ? pwdata[7:0] : mid_q;
        mapped   = paddr inside {HMC_ADDR_FREQ_LO, HMC_ADDR_FREQ_MID, HMC_ADDR_CTRL};
        avg      = ctrl_q[6] ? fast_avg_freq : slow_avg_freq;
        full_src = ctrl_q[7] ? avg : {ctrl_q[2:0], mid_q, lo_q};
        mini_avg = ctrl_q[3] ? slow_avg_freq : fast_avg_freq;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= HMC_RST_CTRL;
            lo_q   <= HMC_RST_FREQ_LO;
            mid_q  <= HMC_RST_FREQ_MID;
        end
        else if (pclk_en)
        begin
            ctrl_q <= ctrl_d;
            lo_q   <= lo_d;
            mid_q  <= mid_d;
        end
    end

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_loss;
        $rose(input_short_loss) && loop_locked && !loop_full_holdover;
    endsequence

    property p_ready; psel && !penable && pclk_en |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error flag wrong for address");
    property p_direct; s_rd(HMC_ADDR_FREQ_LO) ##0 !ctrl_q[5] |=> prdata[7:0] == lo_q; endproperty
    a_direct: assert property (p_direct) else $error("low byte not as written");
    property p_ctrl; s_rd(HMC_ADDR_CTRL) ##0 !ctrl_q[5] |=> prdata == {24'h0, ctrl_q}; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    property p_avg; s_rd(HMC_ADDR_FREQ_MID) ##0 ctrl_q[5] |=> prdata[7:0] == $past(avg[15:8]);
    endproperty
    a_avg: assert property (p_avg) else $error("averaged readback wrong");
    property p_full; s_loss ##0 ctrl_q[4:3] == 2'h0 |=> hold_freq == $past(full_src); endproperty
    a_full: assert property (p_full) else $error("mode 00 not as holdover");
    property p_freeze; s_loss ##0 ctrl_q[4:3] == 2'h1 |=> hold_freq == $past(live_freq)
        ##1 hold_freq == $past(hold_freq); endproperty
    a_freeze: assert property (p_freeze) else $error("freeze value wrong");
    property p_mavg; s_loss ##0 ctrl_q[4] |=> mini_hold_active && hold_freq == $past(mini_avg);
    endproperty
    a_mavg: assert property (p_mavg) else $error("averager mode wrong");
endmodule // hmc_monitor

bind hmc_holdover_mode_control hmc_monitor hmc_monitor_inst (
    .pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .loop_locked, .loop_full_holdover, .input_short_loss, .live_freq,
    .fast_avg_freq, .slow_avg_freq, .hold_freq, .mini_hold_active
);

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the holdover mode control block.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import hmc_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pclk_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'h1;
    logic        loop_locked = 1'b0, loop_full_holdover = 1'b0, input_short_loss = 1'b0;
    logic [18:0] live_freq = 19'h0, fast_avg_freq = 19'h0, slow_avg_freq = 19'h0, hold_freq;
    logic        pready, pslverr, mini_hold_active, full_hold_active;
    logic [7:0]  m_ctrl = 8'h88, m_lo = 8'h00, m_mid = 8'h00;
    logic [15:0] rnd = 16'h0033;
    int          errors = 0, n_compared = 0;

    initial forever #12.5 pclk = ~pclk;

    hmc_holdover_mode_control hmc_holdover_mode_control_inst (
        .pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .loop_locked, .loop_full_holdover, .input_short_loss,
        .live_freq, .fast_avg_freq, .slow_avg_freq, .hold_freq, .mini_hold_active,
        .full_hold_active
    );

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; reads are compared with the model.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1)
        begin
            errors++;
            conclude();
        end
        chk("pslverr", {31'h0, pslverr},
            {31'h0, !(a inside {HMC_ADDR_FREQ_LO, HMC_ADDR_FREQ_MID, HMC_ADDR_CTRL})});
        if (!w)
            chk("prdata", prdata, {24'h0, exp});
        else if (pstrb[0] && a == HMC_ADDR_FREQ_LO)
            m_lo = d;
        else if (pstrb[0] && a == HMC_ADDR_FREQ_MID)
            m_mid = d;
        else if (pstrb[0] && a == HMC_ADDR_CTRL)
            m_ctrl = d;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk_loop(input logic [18:0] ex, input logic mi, input logic fu);
        #1;
        chk("hold_freq", {13'h0, hold_freq}, {13'h0, ex});
        chk("mini_hold_active", {31'h0, mini_hold_active}, {31'h0, mi});
        chk("full_hold_active", {31'h0, full_hold_active}, {31'h0, fu});
    endtask

    initial
    begin
        logic [18:0] ex, avg, word;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, HMC_ADDR_CTRL, 8'h00, 8'h88);
        apb(1'b1, 12'h104, 8'hff, 8'h00);
        apb(1'b0, 12'h104, 8'h00, 8'h00);
        apb(1'b0, HMC_ADDR_FREQ_LO, 8'h00, 8'h00);
        $display("test reset and map done");
        for (int i = 0; i < 6; i++)
        begin
            rnd = nxt(rnd);
            pstrb <= (i == 5) ? 4'h0 : 4'h1;
            apb(1'b1, HMC_ADDR_FREQ_LO + 12'(4 * (i % 3)), rnd[7:0] & ((i % 3 == 2) ? 8'hdf : 8'hff), 8'h00);
            apb(1'b0, HMC_ADDR_FREQ_LO, 8'h00, m_lo);
            apb(1'b0, HMC_ADDR_FREQ_MID, 8'h00, m_mid);
            apb(1'b0, HMC_ADDR_CTRL, 8'h00, m_ctrl);
        end
        pstrb <= 4'h1;
        $display("test direct readback done");
        for (int f = 0; f < 2; f++)
        begin
            rnd = nxt(rnd);
            fast_avg_freq <= {rnd[2:0], rnd};
            slow_avg_freq <= {rnd[15:13], ~rnd};
            avg = f[0] ? {rnd[2:0], rnd} : {rnd[15:13], ~rnd};
            apb(1'b1, HMC_ADDR_CTRL, {1'b1, f[0], 6'h20}, 8'h00);
            apb(1'b0, HMC_ADDR_FREQ_LO, 8'h00, avg[7:0]);
            apb(1'b0, HMC_ADDR_FREQ_MID, 8'h00, avg[15:8]);
            apb(1'b0, HMC_ADDR_CTRL, 8'h00, {m_ctrl[7:3], avg[18:16]});
        end
        $display("test averaged readback done");
        loop_locked <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            rnd = nxt(rnd);
            apb(1'b1, HMC_ADDR_CTRL, {k == 4, rnd[0], 1'b0, 2'(k), rnd[3:1]}, 8'h00);
            word = {m_ctrl[2:0], m_mid, m_lo};
            avg = m_ctrl[6] ? fast_avg_freq : slow_avg_freq;
            live_freq <= {rnd[15:13], rnd ^ 16'h5a5a};
            repeat (2) @(posedge pclk);
            chk_loop(live_freq, 1'b0, 1'b0);
            @(posedge pclk);
            input_short_loss <= 1'b1;
            case (m_ctrl[4:3])
                2'h0: ex = m_ctrl[7] ? avg : word;
                2'h1: ex = live_freq;
                2'h2: ex = fast_avg_freq;
                default: ex = slow_avg_freq;
            endcase
            @(posedge pclk);
            live_freq <= ~live_freq;
            chk_loop(ex, 1'b1, 1'b0);
            @(posedge pclk);
            chk_loop(ex, 1'b1, 1'b0);
            @(posedge pclk);
            input_short_loss <= 1'b0;
            loop_full_holdover <= 1'b1;
            repeat (2) @(posedge pclk);
            chk_loop(m_ctrl[7] ? avg : word, 1'b0, 1'b1);
            @(posedge pclk);
            loop_full_holdover <= 1'b0;
            repeat (2) @(posedge pclk);
            chk_loop(live_freq, 1'b0, 1'b0);
            @(posedge pclk);
        end
        $display("test short loss modes done");
        ex = live_freq;
        pclk_en <= 1'b0;
        live_freq <= ~live_freq;
        repeat (3) @(posedge pclk);
        chk_loop(ex, 1'b0, 1'b0);
        @(posedge pclk);
        pclk_en <= 1'b1;
        repeat (2) @(posedge pclk);
        chk_loop(live_freq, 1'b0, 1'b0);
        @(posedge pclk);
        $display("test clock enable done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_loop(19'h0, 1'b0, 1'b0);
        chk("prdata", prdata, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, HMC_ADDR_CTRL, 8'h00, 8'h88);
        $display("test second reset done");
        conclude();
    end
endmodule // tb_top

`default_nettype wire
